/* logic/drive_conditioning_config.sv */
// Register file, dead-time insertion and turn-on blanking for the gate drives
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
//
// Behaviour
// - Four-bit offset code gives 50 mV per step, 0 to 750 mV.
// - Offset register bits 7-4 read zero; offset field starts unknown (reset here loads zero).
// - Ignore primary sense after turn-on for 50, 100 or 200 ns by code.
// - Blanking code zero gives no blanking at all.
// - Blanking register bits 7-2 read zero; field starts unknown (reset here loads zero).
// - Slope compensation on while bit 6 clear (reset), bypassed when set.
// - Six-bit ramp code N sets rate 4.5 times 1.08 to the N.
// - Dead time only on turn-on edges; primary and secondary independent.
// - Each dead timer enabled only while its bypass bit is clear.
// - Primary turn-on delay from bits 7-4: 16 ns times code plus one (here each step rounds up to 4 cycles, 20 ns).
// - Secondary turn-on delay from bits 3-0, same encoding.
// - Bypass bits at 5 (primary) and 4 (secondary) disable dead time.
module drive_conditioning_config
	import drive_cond_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	output logic      [7:0] reg_rdata,
	// Drive requests from the modulator
	input  wire logic       primary_request,
	input  wire logic       secondary_request,
	// Primary current sense from the comparator
	input  wire logic       primary_sense,
	// Conditioned gate drives
	output logic            primary_drive,
	output logic            secondary_drive,
	// Sense after turn-on blanking
	output logic            primary_sense_gated,
	output logic            turn_on_blanking,
	// Analog settings
	output logic      [3:0] offset_code,
	output logic      [9:0] offset_mv,
	output logic            slope_enable,
	output logic      [5:0] slope_rate_code
);

	// Code 2'b11 unused in all three machines, recovered by default
	typedef enum logic [1:0] {
		DRV_OFF  = 2'b00,
		DRV_DEAD = 2'b01,
		DRV_ON   = 2'b10
	} drive_state_e;

	typedef enum logic [1:0] {
		BLANK_IDLE   = 2'b00,
		BLANK_ACTIVE = 2'b01,
		BLANK_DONE   = 2'b10
	} blank_state_e;

	logic [3:0]       offset_q;
	logic [1:0]       blank_q;
	logic [6:0]       slope_q;
	logic [7:0]       dead_q;
	logic [1:0]       bypass_q;
	logic             preq_q;
	logic             sreq_q;
	logic             prise;
	logic             srise;
	logic [CNT_W-1:0] pcnt_q;
	logic [CNT_W-1:0] scnt_q;
	logic [CNT_W-1:0] bcnt_q;
	logic [CNT_W-1:0] p_len_q;
	logic [CNT_W-1:0] s_len_q;
	logic [CNT_W-1:0] b_len_q;
	logic             p_byp_q;
	logic             s_byp_q;
	drive_state_e     pstate_q;
	drive_state_e     sstate_q;
	blank_state_e     bstate_q;
	logic [7:0]       rdata_q;

	function automatic logic [CNT_W-1:0] dead_cycles(input logic [3:0] code);
		dead_cycles = CNT_W'((int'(code) + 1) * DEAD_STEP_CYC);
	endfunction

	function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: blank_cycles = CNT_W'(0);
			2'h1: blank_cycles = CNT_W'(BLANK_50_CYC);
			2'h2: blank_cycles = CNT_W'(BLANK_100_CYC);
			2'h3: blank_cycles = CNT_W'(BLANK_200_CYC);
		endcase
	endfunction

	// Write decode shared by every register
	function automatic logic write_hit(input logic strobe, input logic [2:0] addr,
		input logic [2:0] target);
		write_hit = strobe && (addr == target);
	endfunction

	always_ff @(posedge clock) begin
		if (reset) begin
			offset_q <= OFFSET_RESET;
		end else if (write_hit(reg_write, reg_addr, OFS_OFFSET)) begin
			offset_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			blank_q <= BLANK_RESET;
		end else if (write_hit(reg_write, reg_addr, OFS_BLANK)) begin
			blank_q <= reg_wdata[1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			slope_q <= SLOPE_RESET;
		end else if (write_hit(reg_write, reg_addr, OFS_SLOPE)) begin
			slope_q <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			dead_q <= DEAD_RESET;
		end else if (write_hit(reg_write, reg_addr, OFS_DEAD)) begin
			dead_q <= reg_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			bypass_q <= BYPASS_RESET;
		end else if (write_hit(reg_write, reg_addr, OFS_PERIPH)) begin
			bypass_q <= {reg_wdata[PRI_BYPASS_BIT], reg_wdata[SEC_BYPASS_BIT]};
		end
	end

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				OFS_OFFSET: rdata_q <= {4'h0, offset_q};
				OFS_BLANK:  rdata_q <= {6'h00, blank_q};
				OFS_SLOPE:  rdata_q <= {1'b0, slope_q};
				OFS_DEAD:   rdata_q <= dead_q;
				OFS_PERIPH: rdata_q <= {2'b00, bypass_q, 4'h0};
				default:    rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			preq_q <= 1'b0;
		end else begin
			preq_q <= primary_request;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sreq_q <= 1'b0;
		end else begin
			sreq_q <= secondary_request;
		end
	end

	// History resets low, matching the idle request level
	assign prise = primary_request & ~preq_q;
	assign srise = secondary_request & ~sreq_q;

	always_ff @(posedge clock) begin
		if (reset) begin
			p_len_q <= '0;
			p_byp_q <= 1'b0;
		end else if (prise) begin
			p_len_q <= dead_cycles(dead_q[7:4]);
			p_byp_q <= bypass_q[1];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			b_len_q <= '0;
		end else if (prise) begin
			b_len_q <= blank_cycles(blank_q);
		end
	end

	// secondary settings at its cycle start
	always_ff @(posedge clock) begin
		if (reset) begin
			s_len_q <= '0;
			s_byp_q <= 1'b0;
		end else if (srise) begin
			s_len_q <= dead_cycles(dead_q[3:0]);
			s_byp_q <= bypass_q[0];
		end
	end

	// primary dead counter restarts on rise
	always_ff @(posedge clock) begin
		if (reset) begin
			pcnt_q <= '0;
		end else if (!primary_request || prise) begin
			pcnt_q <= '0;
		end else if (pcnt_q != p_len_q) begin
			pcnt_q <= pcnt_q + 1'b1;
		end
	end

	// secondary dead counter restarts on rise
	always_ff @(posedge clock) begin
		if (reset) begin
			scnt_q <= '0;
		end else if (!secondary_request || srise) begin
			scnt_q <= '0;
		end else if (scnt_q != s_len_q) begin
			scnt_q <= scnt_q + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pstate_q <= DRV_OFF;
		end else if (!primary_request) begin
			pstate_q <= DRV_OFF;
		end else begin
			unique case (pstate_q)
				DRV_OFF: begin
					pstate_q <= DRV_DEAD;
				end
				// dead timer used only when not bypassed
				DRV_DEAD: begin
					if (p_byp_q || pcnt_q + 1'b1 >= p_len_q) begin
						pstate_q <= DRV_ON;
					end
				end
				DRV_ON: begin
					pstate_q <= DRV_ON;
				end
				default: begin
					pstate_q <= DRV_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sstate_q <= DRV_OFF;
		end else if (!secondary_request) begin
			sstate_q <= DRV_OFF;
		end else begin
			unique case (sstate_q)
				DRV_OFF: begin
					sstate_q <= DRV_DEAD;
				end
				// dead timer used only when not bypassed
				DRV_DEAD: begin
					if (s_byp_q || scnt_q + 1'b1 >= s_len_q) begin
						sstate_q <= DRV_ON;
					end
				end
				DRV_ON: begin
					sstate_q <= DRV_ON;
				end
				default: begin
					sstate_q <= DRV_OFF;
				end
			endcase
		end
	end

	// Bypass still waits one cycle; a state bit drives the gate, glitch free
	assign primary_drive   = pstate_q[1];
	assign secondary_drive = sstate_q[1];

	always_ff @(posedge clock) begin
		if (reset) begin
			bstate_q <= BLANK_IDLE;
			bcnt_q   <= '0;
		end else if (!primary_drive) begin
			bstate_q <= BLANK_IDLE;
			bcnt_q   <= '0;
		end else begin
			unique case (bstate_q)
				BLANK_IDLE: begin
					bcnt_q   <= CNT_W'(1);
					bstate_q <= (CNT_W'(1) < b_len_q) ? BLANK_ACTIVE : BLANK_DONE;
				end
				BLANK_ACTIVE: begin
					bcnt_q   <= bcnt_q + 1'b1;
					bstate_q <= (bcnt_q + 1'b1 < b_len_q) ? BLANK_ACTIVE : BLANK_DONE;
				end
				BLANK_DONE: begin
					bstate_q <= BLANK_DONE;
				end
				default: begin
					bstate_q <= BLANK_IDLE;
				end
			endcase
		end
	end

	assign turn_on_blanking    = primary_drive && (b_len_q != '0) && (bstate_q != BLANK_DONE);
	assign primary_sense_gated = primary_sense & ~turn_on_blanking;

	// offset code and value in mV
	assign offset_code = offset_q;
	assign offset_mv   = 10'(int'(offset_q) * OFFSET_STEP_MV);
	assign slope_enable    = ~slope_q[SLOPE_BYPASS_BIT];
	// code drives the exponential ramp DAC
	assign slope_rate_code = slope_q[5:0];

endmodule

/* logic/drive_cond_pkg.sv */
// Constants for the drive conditioning configuration block
package drive_cond_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] OFS_OFFSET   = 3'h0;
	localparam logic [2:0] OFS_BLANK    = 3'h1;
	localparam logic [2:0] OFS_SLOPE    = 3'h2;
	localparam logic [2:0] OFS_DEAD     = 3'h3;
	localparam logic [2:0] OFS_PERIPH   = 3'h4;
	// Field positions
	localparam int SLOPE_BYPASS_BIT   = 6;
	localparam int PRI_BYPASS_BIT     = 5;
	localparam int SEC_BYPASS_BIT     = 4;
	// Reset values (documented unknowns are given zero)
	localparam logic [3:0] OFFSET_RESET = 4'h0;
	localparam logic [1:0] BLANK_RESET  = 2'h0;
	localparam logic [6:0] SLOPE_RESET  = 7'h00;
	localparam logic [7:0] DEAD_RESET   = 8'h00;
	localparam logic [1:0] BYPASS_RESET = 2'h0;
	// Timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int DEAD_STEP_PS    = 16000;
	localparam int BLANK_50_PS     = 50000;
	localparam int BLANK_100_PS    = 100000;
	localparam int BLANK_200_PS    = 200000;
	localparam int OFFSET_STEP_MV  = 50;
	// Least times round up to whole cycles
	localparam int DEAD_STEP_CYC = (DEAD_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_50_CYC  = (BLANK_50_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_100_CYC = (BLANK_100_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BLANK_200_CYC = (BLANK_200_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 7;
endpackage

/* dv/drive_cond_sva.sv */
// Port checker for the drive conditioning block
`timescale 1ns/1ps
module drive_cond_sva (
	// Clock and reset
	input wire logic       clock,
	input wire logic       reset,
	// Register port
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	// Drives and sense
	input wire logic       primary_request,
	input wire logic       secondary_request,
	input wire logic       primary_sense,
	input wire logic       primary_drive,
	input wire logic       secondary_drive,
	input wire logic       primary_sense_gated,
	input wire logic       turn_on_blanking,
	// Offset setting
	input wire logic [3:0] offset_code,
	input wire logic [9:0] offset_mv
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence dropped(r);
		!r;
	endsequence
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	offset_scale_a: assert property (offset_mv == offset_code * 10'h032)
		else $error("offset mv wrong");
	pri_off_a: assert property (dropped(primary_request) |=> !primary_drive)
		else $error("primary drive not off");
	sec_off_a: assert property (dropped(secondary_request) |=> !secondary_drive)
		else $error("secondary drive not off");
	pri_cause_a: assert property ($rose(primary_drive) |-> $past(primary_request))
		else $error("primary drive without request");
	pri_hold_a: assert property (primary_drive && primary_request |=> primary_drive)
		else $error("primary drive dropped early");
	blank_mask_a: assert property (turn_on_blanking |-> !primary_sense_gated)
		else $error("sense not blanked");
	sense_pass_a: assert property (!turn_on_blanking |-> primary_sense_gated == primary_sense)
		else $error("sense not passed");
endmodule

/* dv/gate_sense_model.sv */
// Gate driver and current sense stand-in
`timescale 1ns/1ps
module gate_sense_model (
	// Drive from the block
	input wire logic primary_drive,
	// Comparator back to the block
	output logic     primary_sense
);
	// Trips at switch-on: worst case for blanking
	assign primary_sense = primary_drive;
endmodule

/* dv/drive_conditioning_config_tb_top.sv */
// Bench for the drive conditioning block
`timescale 1ns/1ps
bind drive_conditioning_config drive_cond_sva drive_cond_sva_i (.clock, .reset, .reg_read,
	.reg_rdata, .primary_request, .secondary_request, .primary_sense, .primary_drive,
	.secondary_drive, .primary_sense_gated, .turn_on_blanking, .offset_code, .offset_mv);
module drive_conditioning_config_tb_top
	import drive_cond_pkg::*;
;
	logic       clock = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
	logic       primary_request = 1'h0, secondary_request = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic       primary_sense, primary_drive, secondary_drive, primary_sense_gated;
	logic       turn_on_blanking, slope_enable;
	logic [3:0] offset_code;
	logic [9:0] offset_mv;
	logic [5:0] slope_rate_code;
	int         n_errors = 0, n_checks = 0;
	logic [7:0] rb [6] = '{8'h0F, 8'h03, 8'h7F, 8'hFF, 8'h30, 8'h00};
	logic [15:0] bl [4] = '{16'h0, 16'(BLANK_50_CYC), 16'(BLANK_100_CYC), 16'(BLANK_200_CYC)};
	initial forever #2.5 clock = ~clock;
	drive_conditioning_config drive_conditioning_config_i (.clock, .reset, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .primary_request, .secondary_request,
		.primary_sense, .primary_drive, .secondary_drive, .primary_sense_gated,
		.turn_on_blanking, .offset_code, .offset_mv, .slope_enable, .slope_rate_code);
	gate_sense_model gate_sense_model_i (.primary_drive, .primary_sense);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_write <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_read <= 1'h1;
		reg_addr <= a;
		@(posedge clock);
		reg_read <= 1'h0;
		#1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask
	// Turn-on latency, then blanked cycles of the primary sense
	task automatic meas(input logic s, input logic [15:0] el, input logic [15:0] eb);
		logic [15:0] n;
		logic [15:0] m;
		n = 0;
		m = 0;
		@(posedge clock);
		if (s) secondary_request <= 1'h1;
		else primary_request <= 1'h1;
		do begin
			@(posedge clock);
			#1 n++;
		end while (n < 200 && (s ? secondary_drive : primary_drive) !== 1'h1);
		chk("latency", el, n);
		repeat (50) begin
			if (turn_on_blanking === 1'h1 && primary_sense_gated === 1'h0) m++;
			@(posedge clock);
			#1;
		end
		chk("blanked", eb, m);
		@(posedge clock);
		primary_request <= 1'h0;
		secondary_request <= 1'h0;
		repeat (3) @(posedge clock);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		#50000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'h0;
		for (int a = 0; a < 6; a++) rd(a[2:0], 8'h00);
		chk("slope_en", 16'h1, {15'h0, slope_enable});
		for (int a = 0; a < 6; a++) wr(a[2:0], 8'hFF);
		for (int a = 0; a < 6; a++) rd(a[2:0], rb[a]);
		chk("offset_mv", 16'(15 * OFFSET_STEP_MV), {6'h00, offset_mv});
		chk("offset_code", 16'hF, {12'h000, offset_code});
		chk("slope_en", 16'h0, {15'h0, slope_enable});
		chk("slope_rate", 16'h3F, {10'h0, slope_rate_code});
		meas(1'h0, 16'h2, bl[3]);
		meas(1'h1, 16'h2, 16'h0);
		wr(OFS_PERIPH, 8'h00);
		for (int b = 0; b < 4; b++) begin
			wr(OFS_BLANK, 8'(b));
			wr(OFS_DEAD, 8'(b * 80 + 15 - b * 5));
			meas(1'h0, 16'((b * 5 + 1) * DEAD_STEP_CYC + 1), bl[b]);
			meas(1'h1, 16'((16 - b * 5) * DEAD_STEP_CYC + 1), 16'h0);
		end
		// Setting changed while the dead timer runs
		fork
			meas(1'h0, 16'(16 * DEAD_STEP_CYC + 1), bl[3]);
			begin
				repeat (4) @(posedge clock);
				wr(OFS_DEAD, 8'h00);
			end
		join
		wr(OFS_PERIPH, 8'h20);
		meas(1'h0, 16'h2, bl[3]);
		meas(1'h1, 16'(DEAD_STEP_CYC + 1), 16'h0);
		wr(OFS_PERIPH, 8'h10);
		meas(1'h0, 16'(DEAD_STEP_CYC + 1), bl[3]);
		meas(1'h1, 16'h2, 16'h0);
		report_and_stop();
	end
endmodule
